// ===== spr_pkg.sv
// ======================================================================
// Shared constants and types
package spr_pkg;

  // ====================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TTL_EN = 8'h04;
  localparam logic [7:0] OFS_INSEL  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // ====================================================================
  // Front connector sources
  localparam logic [2:0] FSRC_ARM  = 3'h0;
  localparam logic [2:0] FSRC_RFT  = 3'h1;
  localparam logic [2:0] FSRC_PRE  = 3'h2;
  localparam logic [2:0] FSRC_ROSC = 3'h3;
  localparam logic [2:0] FSRC_CONV = 3'h4;

  // ECL line sources
  localparam logic [1:0] EFEED_FRONT = 2'h0;
  localparam logic [1:0] EFEED_ROSC  = 2'h1;
  localparam logic [1:0] EFEED_CONV  = 2'h2;

  // TTL shared source
  localparam logic TSRC_ARM   = 1'b0;
  localparam logic TSRC_READY = 1'b1;

  // Input selections used by arm, trigger and oscillator logic
  localparam logic [2:0] SEL_INT   = 3'h0;
  localparam logic [2:0] SEL_ECL0  = 3'h1;
  localparam logic [2:0] SEL_ECL1  = 3'h2;
  localparam logic [2:0] SEL_FRONT = 3'h3;
  localparam logic [2:0] SEL_TTL   = 3'h4;
  localparam logic [2:0] SEL_EXT   = 3'h5;

  // Status bit positions
  localparam int ST_CONFLICT = 0;
  localparam int ST_REJECT   = 1;
  localparam int ST_INIT     = 2;
  localparam int ST_FRONT    = 3;
  localparam int ST_ECL      = 4;
  localparam int ST_TTL      = 8;

  // ====================================================================
  // Timing
  localparam int CLK_MHZ  = 50;
  localparam int CONV_NS  = 25;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;

  // ====================================================================
  // Types
  typedef struct packed {
    logic [1:0][1:0] ecl_src;
    logic            ttl_src;
    logic [2:0]      front_src;
    logic            front_en;
    logic [1:0]      ecl_en;
  } spr_ctrl_t;

  typedef struct packed {
    logic [2:0] rosc;
    logic [2:0] trig;
    logic [2:0] arm2;
    logic [2:0] arm1;
  } spr_insel_t;

  typedef struct packed {
    logic initiated;
    logic initiate;
    logic arm_event;
    logic arm_ready;
    logic cycle_done;
    logic pre_arm_met;
    logic arm_count_gt1;
    logic segment_switch;
    logic meas_done;
    logic convert;
    logic mem_read;
  } spr_acq_t;

  localparam int CTRL_W  = $bits(spr_ctrl_t);
  localparam int INSEL_W = $bits(spr_insel_t);

  localparam spr_ctrl_t CTRL_RST = '{
    ecl_src:   {EFEED_FRONT, EFEED_CONV},
    ttl_src:   TSRC_ARM,
    front_src: FSRC_CONV,
    front_en:  1'b0,
    ecl_en:    2'b00
  };

  localparam spr_insel_t INSEL_RST = '{
    rosc: SEL_INT, trig: SEL_INT, arm2: SEL_INT, arm1: SEL_INT
  };

endpackage

// ===== spr_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Fixed-width pulse on each trigger, retriggerable
module spr_pulse_gen
  import spr_pkg::*;
(
  input  wire logic sys_clk,  // System clock
  input  wire logic rst,      // Synchronous reset
  input  wire logic trig,     // One-cycle trigger
  output logic      pulse     // Pulse, CONV_CYC cycles wide
);

  logic [3:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (trig) begin
      cnt_q <= 4'(CONV_CYC);
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign pulse = (cnt_q != 4'h0);

endmodule
`default_nettype wire

// ===== spr_router.sv
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RL1: Each ECL line has its own enable.
// RL2: Reset leaves both ECL lines disabled.
// RL3: Flag conflict: enabled ECL line also used as input.
// RL4: Ignore output setting writes while initiated.
// RL5: Front arm source low from arm until done.
// RL6: Front ready source low after delay, until done.
// RL7: Front pre-arm source low once count met.
// RL8: Pre-arm level rises at next cycle or initiate.
// RL9: Front oscillator output inverted; external uses falling edge.
// RL10: Oscillator output runs whenever that source selected.
// RL11: Front convert source gives 25 ns low pulse (here CONV_CYC rounds up to 2 cycles, 40 ns at 50 MHz).
// RL12: Memory readout also makes convert pulses.
// RL13: Reset selects convert pulse for front connector.
// RL14: Front output gated by enable, off after reset.
// RL15: Flag conflict: front enabled while arm uses it.
// RL16: One shared source for all eight TTL lines.
// RL17: TTL arm source low from arm until done.
// RL18: TTL ready source low when initiated.
// RL19: Ready high during segment change, low on reinitiate.
// RL20: Ready high after measurement completes.
// RL21: Reset selects arm signal for TTL lines.
// RL22: ECL front feed inverts front, needs front enable.
// RL23: Each TTL line has own enable, off at reset.
// RL24: Level outputs idle high without acquisition (the pre-arm level here stays low until initiate or a later arm).
module spr_router
  import spr_pkg::*;
(
  input  wire logic        sys_clk,       // System clock, 50 MHz
  input  wire logic        rst,           // Synchronous reset, high
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Wishbone write
  input  wire logic [7:0]  wb_adr_i,      // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,      // Wishbone byte enables
  input  wire logic [31:0] wb_dat_i,      // Wishbone write data
  output logic      [31:0] wb_dat_o,      // Wishbone read data
  output logic             wb_ack_o,      // Wishbone acknowledge
  input  wire spr_acq_t    acq,           // Acquisition events
  input  wire logic        rosc_clk,      // Reference oscillator
  output logic             front_out,     // Front connector level
  output logic             front_drive_n, // Front driver on, low
  output logic      [1:0]  ecl_sync_line, // ECL line levels
  output logic      [1:0]  ecl_drive_n,   // ECL drivers on, low
  output logic      [7:0]  ttl_sync_line, // TTL line levels
  output logic      [7:0]  ttl_drive_n    // TTL drivers on, low
);

  // ====================================================================
  // Register bus
  spr_ctrl_t   ctrl_q;
  spr_insel_t  insel_q;
  logic [7:0]  ttl_en_q;
  logic        conflict_q;
  logic        reject_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        req;
  logic        wr_ctrl;
  logic        wr_ttl;
  logic        wr_insel;
  logic        wr_status;
  logic [31:0] ctrl_wr;
  logic [31:0] ttl_wr;
  logic [31:0] insel_wr;
  logic [31:0] status_rd;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign req        = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctrl    = req && wb_we_i && (wb_adr_i == OFS_CTRL);
  assign wr_ttl     = req && wb_we_i && (wb_adr_i == OFS_TTL_EN);
  assign wr_insel   = req && wb_we_i && (wb_adr_i == OFS_INSEL);
  assign wr_status  = req && wb_we_i && (wb_adr_i == OFS_STATUS);
  assign ctrl_wr  = merge(32'(ctrl_q), wb_dat_i, wb_sel_i);
  assign ttl_wr   = merge(32'(ttl_en_q), wb_dat_i, wb_sel_i);
  assign insel_wr = merge(32'(insel_q), wb_dat_i, wb_sel_i);

  // Output settings are frozen during an acquisition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;                      // RL2 RL13 RL14 RL21
    end else if (wr_ctrl && !acq.initiated) begin          // RL4
      ctrl_q <= spr_ctrl_t'(ctrl_wr[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ttl_en_q <= 8'h00;                                    // RL23
    end else if (wr_ttl && !acq.initiated) begin           // RL4
      ttl_en_q <= ttl_wr[7:0];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      insel_q <= INSEL_RST;
    end else if (wr_insel) begin
      insel_q <= spr_insel_t'(insel_wr[INSEL_W-1:0]);
    end
  end

  // ====================================================================
  // Settings conflicts
  logic [1:0] ecl_conflict;
  logic       front_conflict;
  logic       conflict_now;
  for (genvar g = 0; g < 2; g++) begin : g_ecl_conf
    localparam logic [2:0] SEL_ME = (g == 0) ? SEL_ECL0 : SEL_ECL1;
    assign ecl_conflict[g] = ctrl_q.ecl_en[g] &&
      (insel_q.rosc == SEL_ME || insel_q.arm1 == SEL_ME ||
       insel_q.arm2 == SEL_ME || insel_q.trig == SEL_ME);       // RL3
  end

  assign front_conflict = ctrl_q.front_en && (insel_q.arm1 == SEL_FRONT ||
                          insel_q.arm2 == SEL_FRONT);           // RL15
  assign conflict_now   = (|ecl_conflict) || front_conflict;

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conflict_q <= 1'b0;
    end else if (conflict_now) begin                       // RL3 RL15
      conflict_q <= 1'b1;
    end else if (wr_status && wb_sel_i[0] && wb_dat_i[ST_CONFLICT]) begin
      conflict_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else if ((wr_ctrl || wr_ttl) && acq.initiated) begin // RL4
      reject_q <= 1'b1;
    end else if (wr_status && wb_sel_i[0] && wb_dat_i[ST_REJECT]) begin
      reject_q <= 1'b0;
    end
  end

  // ====================================================================
  // Bus answer: ack one cycle after the request, unmapped reads zero
  always_comb begin
    status_rd = 32'h0;
    status_rd[ST_CONFLICT]      = conflict_q;
    status_rd[ST_REJECT]        = reject_q;
    status_rd[ST_INIT]          = acq.initiated;
    status_rd[ST_FRONT]         = front_out;
    status_rd[ST_ECL +: 2]      = ecl_sync_line;
    status_rd[ST_TTL +: 8]      = ttl_sync_line;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req;
      if (req) begin
        unique case (wb_adr_i)
          OFS_CTRL:   rdat_q <= 32'(ctrl_q);
          OFS_TTL_EN: rdat_q <= {24'h0, ttl_en_q};
          OFS_INSEL:  rdat_q <= 32'(insel_q);
          OFS_STATUS: rdat_q <= status_rd;
          default:    rdat_q <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ====================================================================
  // Synchronisation levels (high = condition asserted, pin low)
  logic arm_low_q;
  logic rft_low_q;
  logic pre_low_q;
  logic ready_low_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_low_q <= 1'b0;
    end else if (acq.arm_event) begin                      // RL5 RL17
      arm_low_q <= 1'b1;
    end else if (acq.cycle_done || !acq.initiated) begin   // RL24
      arm_low_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rft_low_q <= 1'b0;
    end else if (acq.arm_ready) begin                      // RL6
      rft_low_q <= 1'b1;
    end else if (acq.cycle_done || !acq.initiated) begin   // RL24
      rft_low_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_low_q <= 1'b0;
    end else if (acq.pre_arm_met) begin                    // RL7
      pre_low_q <= 1'b1;
    end else if (acq.initiate ||
                 (acq.arm_event && acq.arm_count_gt1)) begin // RL8
      pre_low_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_low_q <= 1'b0;
    end else if (acq.initiate) begin                       // RL18 RL19
      ready_low_q <= 1'b1;
    end else if (acq.segment_switch) begin                 // RL19
      ready_low_q <= 1'b0;
    end else if (acq.meas_done || !acq.initiated) begin    // RL20 RL24
      ready_low_q <= 1'b0;
    end
  end

  // ====================================================================
  // Reference oscillator and convert pulse
  logic rosc_meta_q;
  logic rosc_q;
  logic rosc_ext;
  logic conv_pulse;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rosc_meta_q <= 1'b0;
      rosc_q      <= 1'b0;
    end else begin
      rosc_meta_q <= rosc_clk;
      rosc_q      <= rosc_meta_q;
    end
  end
  assign rosc_ext = (insel_q.rosc == SEL_EXT);
  spr_pulse_gen u_spr_pulse_gen (
    .sys_clk (sys_clk),
    .rst     (rst),
    .trig    (acq.convert || acq.mem_read),                 // RL11 RL12
    .pulse   (conv_pulse)
  );

  // ====================================================================
  // Front connector
  logic front_sig;
  always_comb begin
    unique case (ctrl_q.front_src)
      FSRC_ARM:  front_sig = !arm_low_q;                    // RL5
      FSRC_RFT:  front_sig = !rft_low_q;                    // RL6
      FSRC_PRE:  front_sig = !pre_low_q;                    // RL7
      FSRC_ROSC: front_sig = rosc_ext ? rosc_q : !rosc_q;   // RL9 RL10
      FSRC_CONV: front_sig = !conv_pulse;                   // RL11
      default:   front_sig = 1'b1;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      front_out     <= 1'b1;
      front_drive_n <= 1'b1;
    end else begin
      front_out     <= ctrl_q.front_en ? front_sig : 1'b1;  // RL14
      front_drive_n <= !ctrl_q.front_en;                    // RL14
    end
  end

  // ====================================================================
  // ECL lines, each with its own feed and enable
  for (genvar g = 0; g < 2; g++) begin : g_ecl
    logic sig;
    always_comb begin
      unique case (ctrl_q.ecl_src[g])
        EFEED_FRONT: sig = ctrl_q.front_en && !front_sig;  // RL22
        EFEED_ROSC:  sig = rosc_ext ? !rosc_q : rosc_q;
        EFEED_CONV:  sig = conv_pulse;
        default:     sig = 1'b0;
      endcase
    end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        ecl_sync_line[g] <= 1'b0;
        ecl_drive_n[g]   <= 1'b1;
      end else begin
        ecl_sync_line[g] <= ctrl_q.ecl_en[g] ? sig : 1'b0;  // RL1
        ecl_drive_n[g]   <= !ctrl_q.ecl_en[g];              // RL1
      end
    end
  end

  // ====================================================================
  // TTL lines share one feed, enabled one by one
  logic ttl_sig;
  assign ttl_sig = (ctrl_q.ttl_src == TSRC_ARM) ? !arm_low_q   // RL16
                                                : !ready_low_q;
  for (genvar g = 0; g < 8; g++) begin : g_ttl
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        ttl_sync_line[g] <= 1'b1;
        ttl_drive_n[g]   <= 1'b1;
      end else begin
        ttl_sync_line[g] <= ttl_en_q[g] ? ttl_sig : 1'b1;   // RL23
        ttl_drive_n[g]   <= !ttl_en_q[g];                   // RL23
      end
    end
  end

  // ====================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_defaults: assert property ( // RL2 RL13 RL14 RL21
    $fell(rst) |-> ctrl_q.ecl_en == 2'b00 && !ctrl_q.front_en &&
      ctrl_q.front_src == FSRC_CONV && ctrl_q.ttl_src == TSRC_ARM &&
      ttl_en_q == 8'h00)
    else $error("reset values wrong");
  a_reject_frozen: assert property ( // RL4
    (wr_ctrl && acq.initiated) |=> $stable(ctrl_q) && reject_q)
    else $error("setting changed while initiated");
  a_ecl_conflict: assert property ( // RL3
    (|ecl_conflict) |=> conflict_q)
    else $error("ECL conflict not flagged");
  a_front_conflict: assert property ( // RL15
    front_conflict |=> conflict_q)
    else $error("front conflict not flagged");
  a_front_arm_low: assert property ( // RL5
    (acq.arm_event && ctrl_q.front_en && ctrl_q.front_src == FSRC_ARM &&
     acq.initiated) |=> ##1 !front_out)
    else $error("arm did not pull front low");
  a_pre_arm_high: assert property ( // RL8
    (acq.initiate && !acq.pre_arm_met) |=> !pre_low_q)
    else $error("pre-arm level not released");
  a_front_gate_off: assert property ( // RL14
    !ctrl_q.front_en |=> front_out && front_drive_n)
    else $error("front driven while disabled");
  a_conv_width: assert property ( // RL11
    (acq.convert && acq.initiated && ctrl_q.front_en &&
     ctrl_q.front_src == FSRC_CONV) |-> ##2 !front_out[*2])
    else $error("convert pulse too short");
  a_ecl_front_inv: assert property ( // RL22
    (ctrl_q.ecl_src[1] == EFEED_FRONT && ctrl_q.ecl_en[1] &&
     ctrl_q.front_en) |=> ecl_sync_line[1] != front_out)
    else $error("ECL front feed not inverted");
  a_ttl_shared: assert property ( // RL16
    ((ttl_sync_line & ~ttl_drive_n) == 8'h00) ||
    ((ttl_sync_line | ttl_drive_n) == 8'hff))
    else $error("TTL lines disagree");
  a_ready_init: assert property ( // RL18
    (acq.initiate && ctrl_q.ttl_src == TSRC_READY && ttl_en_q[0] &&
     acq.initiated) |=> ##1 !ttl_sync_line[0])
    else $error("ready did not go low");

endmodule
`default_nettype wire

// ===== spr_backplane_model.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Peer modules on the backplane: resolve the shared trigger wires
module spr_backplane_model (
  input  wire logic [7:0] ttl_sync_line, // Router TTL levels
  input  wire logic [7:0] ttl_drive_n,   // Router TTL drivers, low on
  input  wire logic [1:0] ecl_sync_line, // Router ECL levels
  input  wire logic [1:0] ecl_drive_n,   // Router ECL drivers, low on
  output logic      [7:0] ttl_wire,      // TTL wire seen by peers
  output logic      [1:0] ecl_wire       // ECL wire seen by peers
);
  // TTL wires are pulled up, so an undriven line reads high
  assign ttl_wire = ~(~ttl_drive_n & ~ttl_sync_line);
  // ECL wires terminate low when no driver is on
  assign ecl_wire = ~ecl_drive_n & ecl_sync_line;
endmodule
`default_nettype wire

// ===== spr_router_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Bench for the sync output router
module spr_router_tb_top
  import spr_pkg::*;
;
  localparam int B_INI = 9;
  localparam int B_ARM = 8;
  localparam int B_RDY = 7;
  localparam int B_DONE = 6;
  localparam int B_PRE = 5;
  localparam int B_SEG = 3;
  localparam int B_MEAS = 2;
  localparam int B_CONV = 1;
  localparam int B_MRD = 0;
  logic        sys_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, rosc_clk;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rd, rv;
  logic [3:0]  rcnt = 4'h0;
  spr_acq_t    acq;
  logic        front_out, front_drive_n;
  logic [1:0]  ecl_sync_line, ecl_drive_n, ecl_wire;
  logic [7:0]  ttl_sync_line, ttl_drive_n, ttl_wire;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  int          tgl;
  // Conflict cases: input selection, enables, flag expected
  logic [31:0] c_ins [6] = '{32'h1, 32'h10, 32'h40, 32'h400, 32'h3, 32'h1};
  logic [2:0]  c_en [6] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h4, 3'h2};
  logic [5:0]  c_exp = 6'b011111;

  assign rosc_clk = rcnt[3];

  spr_router u_spr_router (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .acq(acq), .rosc_clk(rosc_clk),
    .front_out(front_out), .front_drive_n(front_drive_n),
    .ecl_sync_line(ecl_sync_line), .ecl_drive_n(ecl_drive_n),
    .ttl_sync_line(ttl_sync_line), .ttl_drive_n(ttl_drive_n));

  spr_backplane_model u_spr_backplane_model (
    .ttl_sync_line(ttl_sync_line), .ttl_drive_n(ttl_drive_n),
    .ecl_sync_line(ecl_sync_line), .ecl_drive_n(ecl_drive_n),
    .ttl_wire(ttl_wire), .ecl_wire(ecl_wire));

  // ====================================================================
  // Clock, oscillator and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    rcnt <= rcnt + 4'h1;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ====================================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Front, ECL and TTL levels in one vector
  task automatic lv(input logic [10:0] e);
    chk({21'h0, front_out, ecl_sync_line, ttl_sync_line}, {21'h0, e});
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rv = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  task automatic stp(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle event; returns where its output effect is visible
  task automatic pulse(input int b);
    @(posedge sys_clk);
    acq[b] <= 1'b1;
    @(posedge sys_clk);
    acq[b] <= 1'b0;
    stp(1);
  endtask

  task automatic ini(input logic v, input logic g);
    @(posedge sys_clk);
    acq.initiated <= v;
    acq.arm_count_gt1 <= g;
    stp(2);
  endtask

  function automatic logic [31:0] cf(input logic t, input logic [2:0] f,
                                     input logic fe, input logic [1:0] ee);
    return {21'h0, EFEED_FRONT, EFEED_CONV, t, f, fe, ee};
  endfunction

  // ====================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    acq = '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(OFS_CTRL, 32'hffffffff, 32'h120);
    rdc(OFS_TTL_EN, 32'hffffffff, 32'h0);
    rdc(8'h10, 32'hffffffff, 32'h0);
    chk({front_drive_n, ecl_drive_n, ttl_drive_n}, 32'h7ff);
    lv(11'h4ff);
    // Convert and readout pulses with the front and convert ECL feeds in use
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_CONV, 1'b1, 2'b11));
    stp(2);
    chk({front_drive_n, ecl_drive_n}, 32'h0);
    ini(1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      pulse(i == 0 ? B_CONV : B_MRD);
      lv(11'h3ff);
      chk(ecl_wire, 32'h3);
      stp(1);
      lv(11'h3ff);
      stp(1);
      lv(11'h4ff);
    end
    ini(1'b0, 1'b0);
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_CONV, 1'b0, 2'b10));
    stp(2);
    chk({front_drive_n, ecl_drive_n}, 32'h5);
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_CONV, 1'b0, 2'b11));
    pulse(B_CONV);
    lv(11'h5ff);
    // Arm level on front and TTL lines
    wb(1'b1, OFS_TTL_EN, 32'h5a);
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_ARM, 1'b1, 2'b00));
    ini(1'b1, 1'b0);
    pulse(B_ARM);
    lv(11'h0a5);
    chk(ttl_drive_n, 32'ha5);
    chk(ttl_wire, 32'ha5);
    stp(3);
    lv(11'h0a5);
    pulse(B_DONE);
    lv(11'h4ff);
    pulse(B_ARM);
    ini(1'b0, 1'b0);
    lv(11'h4ff);
    // Ready for trigger waits for the arm delay
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_RFT, 1'b1, 2'b00));
    ini(1'b1, 1'b0);
    pulse(B_ARM);
    lv(11'h4a5);
    pulse(B_RDY);
    lv(11'h0a5);
    pulse(B_DONE);
    lv(11'h4ff);
    ini(1'b0, 1'b0);
    // Pre-arm count level
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_PRE, 1'b1, 2'b00));
    ini(1'b1, 1'b1);
    pulse(B_PRE);
    lv(11'h0ff);
    pulse(B_ARM);
    lv(11'h4a5);
    pulse(B_DONE);
    pulse(B_PRE);
    ini(1'b0, 1'b0);
    lv(11'h0ff);
    pulse(B_INI);
    lv(11'h4ff);
    // TTL ready level, with writes refused while initiated
    wb(1'b1, OFS_CTRL, cf(TSRC_READY, FSRC_CONV, 1'b0, 2'b00));
    wb(1'b1, OFS_TTL_EN, 32'hff);
    ini(1'b1, 1'b1);
    pulse(B_INI);
    lv(11'h400);
    wb(1'b1, OFS_CTRL, 32'h0);
    wb(1'b1, OFS_TTL_EN, 32'h0);
    rdc(OFS_CTRL, 32'hffffffff, cf(TSRC_READY, FSRC_CONV, 1'b0, 2'b00));
    rdc(OFS_TTL_EN, 32'hffffffff, 32'hff);
    rdc(OFS_STATUS, 32'h6, 32'h6);
    pulse(B_SEG);
    lv(11'h4ff);
    pulse(B_INI);
    lv(11'h400);
    ini(1'b1, 1'b0);
    pulse(B_MEAS);
    lv(11'h4ff);
    ini(1'b0, 1'b0);
    wb(1'b1, OFS_STATUS, 32'h2);
    rdc(OFS_STATUS, 32'h2, 32'h0);
    // Settings conflicts against input selections
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, OFS_INSEL, c_ins[i]);
      wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_CONV, c_en[i][2], c_en[i][1:0]));
      stp(2);
      rdc(OFS_STATUS, 32'h1, {31'h0, c_exp[i]});
      wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_CONV, 1'b0, 2'b00));
      wb(1'b1, OFS_STATUS, 32'h1);
    end
    // Reference oscillator, internal then external
    wb(1'b1, OFS_INSEL, 32'h0);
    wb(1'b1, OFS_CTRL, cf(TSRC_ARM, FSRC_ROSC, 1'b1, 2'b00));
    stp(8);
    tgl = 0;
    for (int i = 0; i < 96; i++) begin
      rv[0] = front_out;
      stp(1);
      if (rv[0] !== front_out)
        tgl++;
    end
    chk(32'(tgl >= 10), 32'h1);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        wb(1'b1, OFS_INSEL, {20'h0, SEL_EXT, 9'h0});
        stp(8);
      end
      do stp(1); while (rcnt !== 4'he);
      chk({31'h0, front_out}, m);
    end
    conclude();
  end
endmodule
`default_nettype wire
